// ### rtl/spi_master_slave_port.sv
// Serial peripheral port, master or slave, with Avalon-MM registers
// How it works
// - output pin driven only with direction set
// - pins used as inputs ignore direction bits
// - unselected slave floats its data output
// - data bit leads latching edge by half
// - eight clock cycles exchange one byte
// - rate field matters in master mode only
// - master seeing select low flags mode fault
// - select direction bit set disables fault detection
// - phase zero: select gates clock, rises between
// - fault clears master bit and pin directions, keeps interrupt enable
// - busy data write flags collision, is dropped
// - collisions caught in master and slave
// - master transfer: data write to done flag
// - slave phase zero: select spans, eighth sample
// - slave phase one: first active edge starts
// - done or fault interrupts when enabled, unmasked
// - enable off: plain port pins, divider stops
// - master select pin: fault input or output
// - open drain option for the four pins
// - master bit clear means slave mode
// - master clock idles at polarity level
// - prescale bit adds divide by four
// - done clears by status read, data access
`timescale 1ns/100ps
module spi_master_slave_port (
   input  wire logic                           I_REF_CLK,
   input  wire logic                           I_NRST,
   input  wire logic [spi_port_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
   input  wire logic                           I_AVS_READ,
   input  wire logic                           I_AVS_WRITE,
   input  wire logic [31:0]                    I_AVS_WRITEDATA,
   input  wire logic [3:0]                     I_AVS_BYTEENABLE,
   output wire logic [31:0]                    O_AVS_READDATA,
   output wire logic                           O_AVS_WAITREQUEST,
   input  wire logic                           I_CCR_IMASK,
   output wire logic                           O_SPI_IRQ,
   input  wire logic                           I_MISO,
   output wire logic                           O_MISO,
   output wire logic                           O_MISO_OE,
   input  wire logic                           I_MOSI,
   output wire logic                           O_MOSI,
   output wire logic                           O_MOSI_OE,
   input  wire logic                           I_SCK,
   output wire logic                           O_SCK,
   output wire logic                           O_SCK_OE,
   input  wire logic                           I_SS_N,
   output wire logic                           O_SS_N,
   output wire logic                           O_SS_N_OE
);
   import spi_port_pkg::*;

   function automatic logic flag_next(input logic set, input logic flag,
                                      input logic arm, input logic clr);
      flag_next = set | (flag & ~(arm & clr));
   endfunction

   function automatic logic arm_next(input logic flag, input logic arm,
                                     input logic rd, input logic clr);
      arm_next = flag & ~clr & (arm | rd);
   endfunction

   logic [7:0]    ctrl_r;
   logic [5:2]    dir_r;
   logic [5:2]    port_r;
   logic          presc_r;
   logic [5:2]    pin_s1_r;
   logic [5:2]    pin_s2_r;
   logic [5:2]    pin_s3_r;
   logic [5:2]    pin_out_r;
   logic [5:2]    pin_oe_r;
   logic [7:0]    shift_r;
   logic [7:0]    rx_buf_r;
   logic [7:0]    rdata_r;
   logic          out_bit_r;
   logic          sck_r;
   logic          ack_r;
   logic          irq_r;
   logic          done_r;
   logic          write_collision_flag_r;
   logic          mode_fault_flag_r;
   logic          done_arm_r;
   logic          write_collision_flag_arm_r;
   logic          mode_fault_flag_arm_r;
   logic [3:0]    edge_cnt_r;
   logic [2:0]    bit_cnt_r;
   logic [3:0]    msamp_r;
   // Pin synchroniser lag seen by the master's own data input
   localparam int CAP_LAG = 3;
   logic [CAP_LAG-1:0] mcap_r;
   logic [CAP_LAG-1:0] mend_r;
   logic [7:0]    mrx_r;
   eng_state_type state_r;
   eng_state_type state_nxt;

   rate_if rif ();

   sck_rate_gen #(
      .CNT_W (7)
   ) u_rate (
      .I_REF_CLK (I_REF_CLK),
      .I_NRST    (I_NRST),
      .rif       (rif)
   );

   // Control fields
   wire irqen  = ctrl_r[B_IRQEN];
   wire serial_system_enable    = ctrl_r[B_SPE];
   wire odrain = ctrl_r[B_ODRAIN];
   wire master_select   = ctrl_r[B_MASTER_SELECT];
   wire clock_polarity_sel   = ctrl_r[B_CLOCK_POLARITY_SEL];
   wire clock_phase_sel   = ctrl_r[B_CLOCK_PHASE_SEL];

   // Bus decode; a request takes effect on the edge that ends its wait
   wire             req      = I_AVS_READ | I_AVS_WRITE;
   wire [IDX_W-1:0] idx      = I_AVS_ADDRESS[ADDR_W-1:2];
   wire             rd       = I_AVS_READ & ack_r;
   wire             wr       = I_AVS_WRITE & ack_r & I_AVS_BYTEENABLE[0];
   wire [7:0]       wdata    = I_AVS_WRITEDATA[7:0];
   wire             wr_ctrl  = wr & (idx == IDX_CTRL);
   wire             wr_data  = wr & (idx == IDX_DATA);
   wire             wr_dir   = wr & (idx == IDX_DIR);
   wire             wr_port  = wr & (idx == IDX_PORT);
   wire             wr_opt   = wr & (idx == IDX_OPT);
   wire             stat_rd  = rd & (idx == IDX_STAT);
   wire [7:0]       seen     = {8{stat_rd}} & rdata_r;
   wire             data_acc = (rd | wr) & (idx == IDX_DATA);

   wire [7:0] stat_val = {done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
   wire [7:0] rd_mux =
      (idx == IDX_CTRL) ? ctrl_r :
      (idx == IDX_STAT) ? stat_val :
      (idx == IDX_DATA) ? rx_buf_r :
      (idx == IDX_DIR)  ? {2'b00, dir_r, 2'b00} :
      (idx == IDX_PORT) ? {2'b00, pin_s2_r, 2'b00} :
      (idx == IDX_OPT)  ? {5'h00, presc_r, 2'b00} : 8'h00;

   // Synchronised pin levels; third stage only feeds edge detection
   wire ss_s    = pin_s2_r[P_SS];
   wire sck_s   = pin_s2_r[P_SCK];
   wire ss_prev = pin_s3_r[P_SS];
   wire sck_chg = sck_s ^ pin_s3_r[P_SCK];

   wire is_master = (state_r == ST_MASTER);
   wire is_slave  = (state_r == ST_SLAVE);
   wire busy      = (state_r != ST_IDLE);
   wire slave_sel = serial_system_enable & ~master_select & ~ss_s;
   wire ss_fall   = ~ss_s & ss_prev;

   // Slave shift clock only counts while selected
   wire s_lead  = slave_sel & sck_chg & (sck_s != clock_polarity_sel);
   wire s_trail = slave_sel & sck_chg & (sck_s == clock_polarity_sel) & is_slave;
   wire m_lead  = rif.tick & ~edge_cnt_r[0];
   wire m_trail = rif.tick & edge_cnt_r[0];
   wire lead    = is_master ? m_lead
                            : s_lead & (is_slave | clock_phase_sel);
   wire trail   = is_master ? m_trail : s_trail;
   // Data changes on one edge and is latched half a period later
   wire sample  = clock_phase_sel ? trail : lead;
   wire drive   = clock_phase_sel ? lead : trail;

   wire [7:0] shift_nxt = {shift_r[6:0],
                           is_master ? pin_s2_r[P_MISO] : pin_s2_r[P_MOSI]};
   wire last_sample = sample & (bit_cnt_r == LAST_BIT);
   wire m_end       = is_master & rif.tick & (edge_cnt_r == EDGE_LAST);
   wire s_done      = is_slave & last_sample;
   // Master input is captured late by the synchroniser lag, so data
   // still lines up at the fastest rate; done waits for the last bit
   wire       m_tail   = |mend_r;
   wire       m_cap    = mcap_r[CAP_LAG-1];
   wire [7:0] mrx_nxt  = {mrx_r[6:0], pin_s2_r[P_MISO]};
   wire       set_done = mend_r[CAP_LAG-1] | s_done;
   wire       tx_busy  = busy | m_tail;

   // Fault only while select serves as the error input
   wire mode_fault_flag_evt = serial_system_enable & master_select & ~dir_r[P_SS] & ~ss_s;
   wire inhibit  = done_r & ~done_arm_r;
   wire write_collision_flag_evt = wr_data & tx_busy;
   wire start_m  = wr_data & serial_system_enable & master_select & ~tx_busy & ~inhibit & ~mode_fault_flag_evt;
   wire load_s   = wr_data & ~master_select & ~tx_busy & ~inhibit;

   // Pin ownership: port function when disabled, select pin as
   // output only in master mode with its direction bit set
   wire [5:2] gp_own   = {~serial_system_enable | master_select, {3{~serial_system_enable}}};
   wire [5:2] spi_out  = {1'b0, {2{serial_system_enable & master_select}},
                          serial_system_enable & ~master_select & ~ss_s};
   wire [5:2] spi_val  = {1'b0, sck_r, out_bit_r, out_bit_r};
   wire [5:2] drv      = dir_r & (spi_out | gp_own);
   wire [5:2] pin_val  = (gp_own & port_r) | (~gp_own & spi_val);
   wire [5:2] oe_nxt   = drv & ~({4{odrain}} & pin_val);
   wire [5:2] out_nxt  = pin_val & ~{4{odrain}};

   assign rif.run  = is_master & serial_system_enable;
   assign rif.code = {presc_r, ctrl_r[1:0]};

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_m)
               state_nxt = ST_MASTER;
            else if (slave_sel && (clock_phase_sel ? s_lead : ss_fall))
               state_nxt = ST_SLAVE;
         end
         ST_MASTER: begin
            if (m_end || !master_select || !serial_system_enable || mode_fault_flag_evt)
               state_nxt = ST_IDLE;
         end
         ST_SLAVE: begin
            // Select rising ends or aborts a slave byte
            if (!serial_system_enable || master_select || ss_s || (clock_phase_sel && last_sample))
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pin_s1_r <= PIN_RESET;
         pin_s2_r <= PIN_RESET;
         pin_s3_r <= PIN_RESET;
      end else begin
         pin_s1_r <= {I_SS_N, I_SCK, I_MOSI, I_MISO};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ack_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ack_r <= req & ~ack_r;
         if (req && !ack_r)
            rdata_r <= rd_mux;
      end
   end

   // A fault outranks a software write in the same cycle
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ctrl_r  <= CTRL_RESET;
         dir_r   <= 4'h0;
         port_r  <= 4'h0;
         presc_r <= 1'b0;
      end else begin
         if (mode_fault_flag_evt)
            ctrl_r[B_MASTER_SELECT] <= 1'b0;
         else if (wr_ctrl)
            ctrl_r <= wdata;
         if (mode_fault_flag_evt)
            dir_r <= 4'h0;
         else if (wr_dir)
            dir_r <= wdata[5:2];
         if (wr_port)
            port_r <= wdata[5:2];
         if (wr_opt)
            presc_r <= wdata[O_PRESC];
      end
   end

   // Set always wins over the clear sequence; a status read arms
   // the clear only for flags it actually returned
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         done_r     <= 1'b0;
         write_collision_flag_r     <= 1'b0;
         mode_fault_flag_r     <= 1'b0;
         done_arm_r <= 1'b0;
         write_collision_flag_arm_r <= 1'b0;
         mode_fault_flag_arm_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         done_r     <= flag_next(set_done, done_r, done_arm_r, data_acc);
         write_collision_flag_r     <= flag_next(write_collision_flag_evt, write_collision_flag_r, write_collision_flag_arm_r, data_acc);
         mode_fault_flag_r     <= flag_next(mode_fault_flag_evt, mode_fault_flag_r, mode_fault_flag_arm_r, wr_ctrl);
         done_arm_r <= arm_next(done_r, done_arm_r, seen[S_DONE], data_acc);
         write_collision_flag_arm_r <= arm_next(write_collision_flag_r, write_collision_flag_arm_r, seen[S_WRITE_COLLISION_FLAG], data_acc);
         mode_fault_flag_arm_r <= arm_next(mode_fault_flag_r, mode_fault_flag_arm_r, seen[S_MODE_FAULT_FLAG], wr_ctrl);
         irq_r <= irqen & (done_r | mode_fault_flag_r) & ~I_CCR_IMASK;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_r    <= ST_IDLE;
         edge_cnt_r <= 4'h0;
         bit_cnt_r  <= 3'h0;
         sck_r      <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == ST_IDLE) begin
            edge_cnt_r <= 4'h0;
            bit_cnt_r  <= 3'h0;
         end else begin
            if (rif.tick)
               edge_cnt_r <= edge_cnt_r + 1'b1;
            if (sample)
               bit_cnt_r <= bit_cnt_r + 1'b1;
         end
         if (is_master)
            sck_r <= sck_r ^ rif.tick;
         else
            sck_r <= clock_polarity_sel;
      end
   end

   // Writes land in the shifter only while idle
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         shift_r   <= 8'h00;
         out_bit_r <= 1'b0;
         rx_buf_r  <= 8'h00;
      end else begin
         if (start_m || load_s)
            shift_r <= wdata;
         else if (sample)
            shift_r <= shift_nxt;
         if (start_m)
            out_bit_r <= wdata[7];
         else if (drive || (state_r == ST_IDLE && slave_sel && ss_fall))
            out_bit_r <= shift_r[7];
         if (mend_r[CAP_LAG-1])
            rx_buf_r <= m_cap ? mrx_nxt : mrx_r;
         else if (s_done)
            rx_buf_r <= sample ? shift_nxt : shift_r;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         pin_out_r <= PIN_RESET;
         pin_oe_r  <= 4'h0;
      end else begin
         pin_out_r <= out_nxt;
         pin_oe_r  <= oe_nxt;
      end
   end

   assign O_AVS_WAITREQUEST = req & ~ack_r;
   assign O_AVS_READDATA    = {24'h00_0000, rdata_r};
   assign O_SPI_IRQ         = irq_r;
   assign O_MISO            = pin_out_r[P_MISO];
   assign O_MISO_OE         = pin_oe_r[P_MISO];
   assign O_MOSI            = pin_out_r[P_MOSI];
   assign O_MOSI_OE         = pin_oe_r[P_MOSI];
   assign O_SCK             = pin_out_r[P_SCK];
   assign O_SCK_OE          = pin_oe_r[P_SCK];
   assign O_SS_N            = pin_out_r[P_SS];
   assign O_SS_N_OE         = pin_oe_r[P_SS];

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mcap_r <= '0;
         mend_r <= '0;
         mrx_r  <= 8'h00;
      end else begin
         mcap_r <= {mcap_r[CAP_LAG-2:0], is_master & sample};
         mend_r <= {mend_r[CAP_LAG-2:0], m_end};
         if (m_cap)
            mrx_r <= mrx_nxt;
      end
   end

   // Master samples counted per byte, read only by a check below
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST)
         msamp_r <= 4'h0;
      else if (start_m)
         msamp_r <= 4'h0;
      else if (is_master && sample)
         msamp_r <= msamp_r + 1'b1;
   end

   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_NRST);

   sequence s_clear_done;
      done_arm_r && data_acc && !set_done;
   endsequence

   sequence s_fault;
      mode_fault_flag_evt;
   endsequence

   a_dir_clear_input: assert property (
      !dir_r[P_MOSI] |=> !O_MOSI_OE)
      else $error("pin driven with direction bit clear");
   a_miso_as_input: assert property (
      serial_system_enable && master_select |=> !O_MISO_OE)
      else $error("master drove its data input");
   a_miso_unselected: assert property (
      serial_system_enable && !master_select && ss_s |=> !O_MISO_OE)
      else $error("unselected slave drove data out");
   a_mode_fault_flag_flag: assert property (
      s_fault |=> mode_fault_flag_r)
      else $error("mode fault not flagged");
   a_mode_fault_flag_disarm: assert property (
      s_fault |=> !ctrl_r[B_MASTER_SELECT] && dir_r == 4'h0 ##1 !is_master)
      else $error("mode fault left drivers enabled");
   a_dir5_no_fault: assert property (
      dir_r[P_SS] && !mode_fault_flag_r |=> !mode_fault_flag_r)
      else $error("fault raised with select as output");
   a_write_collision_flag_write: assert property (
      write_collision_flag_evt && !sample |=> write_collision_flag_r && shift_r == $past(shift_r))
      else $error("collision not flagged or data leaked");
   a_sck_idle: assert property (
      (!busy && $stable(ctrl_r))[*2] |-> sck_r == clock_polarity_sel)
      else $error("serial clock not at idle level");
   a_master_eight: assert property (
      m_end |-> msamp_r + {3'b000, sample} == BYTE_BITS)
      else $error("master byte not eight bits");
   a_slave_done: assert property (
      s_done |=> done_r && rx_buf_r == $past(shift_nxt))
      else $error("slave byte not delivered");
   a_irq_request: assert property (
      irqen && (done_r || mode_fault_flag_r) && !I_CCR_IMASK |=> O_SPI_IRQ)
      else $error("interrupt not requested");
   a_spe_off: assert property (
      !serial_system_enable |=> !busy ##1 !rif.tick)
      else $error("engine active while disabled");
   a_open_drain: assert property (
      odrain |=> !O_MOSI && !O_SCK && !O_MISO && !O_SS_N)
      else $error("open drain pin driven high");
   a_done_clear: assert property (
      s_clear_done |=> !done_r)
      else $error("done flag did not clear");
   a_slave_no_rate: assert property (
      !master_select |=> !rif.run)
      else $error("divider ran in slave mode");
endmodule

// ### rtl/spi_port_pkg.sv
// Shared constants, register map and types of the serial peripheral port
package spi_port_pkg;
   localparam int ADDR_W = 8;
   localparam int IDX_W  = 6;
   // Register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL = 6'h28;
   localparam logic [IDX_W-1:0] IDX_STAT = 6'h29;
   localparam logic [IDX_W-1:0] IDX_DATA = 6'h2A;
   localparam logic [IDX_W-1:0] IDX_DIR  = 6'h30;
   localparam logic [IDX_W-1:0] IDX_PORT = 6'h31;
   localparam logic [IDX_W-1:0] IDX_OPT  = 6'h38;
   localparam logic [7:0] CTRL_RESET = 8'h04;
   localparam logic [3:0] PIN_RESET  = 4'h8;
   // Control fields
   localparam int B_IRQEN  = 7;
   localparam int B_SPE    = 6;
   localparam int B_ODRAIN = 5;
   localparam int B_MASTER_SELECT   = 4;
   localparam int B_CLOCK_POLARITY_SEL   = 3;
   localparam int B_CLOCK_PHASE_SEL   = 2;
   // Status and option fields
   localparam int S_DONE   = 7;
   localparam int S_WRITE_COLLISION_FLAG   = 6;
   localparam int S_MODE_FAULT_FLAG   = 4;
   localparam int O_PRESC  = 2;
   // Port pin numbers shared with the serial function
   localparam int P_MISO = 2;
   localparam int P_MOSI = 3;
   localparam int P_SCK  = 4;
   localparam int P_SS   = 5;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] EDGE_LAST = 4'hF;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] DIV_RATIO [0:7] = '{8'h02, 8'h04, 8'h10, 8'h20,
                                              8'h08, 8'h10, 8'h40, 8'h80};
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE  = 2'b10
   } eng_state_type;
   // Half of the divide ratio: reference cycles per clock phase
   function automatic logic [6:0] half_period(input logic [2:0] code);
      half_period = DIV_RATIO[code][7:1];
   endfunction
endpackage

// ### rtl/rate_if.sv
// Link between the transfer engine and the serial clock divider
`timescale 1ns/100ps
interface rate_if;
   logic       run;
   logic [2:0] code;
   logic       tick;
   modport gen  (input run, input code, output tick);
   modport user (output run, output code, input tick);
endinterface

// ### rtl/sck_rate_gen.sv
// Divider that marks each half period of the master serial clock
`timescale 1ns/100ps
module sck_rate_gen #(
   parameter int CNT_W = 7
) (
   input wire logic I_REF_CLK,
   input wire logic I_NRST,
   rate_if.gen      rif
);
   import spi_port_pkg::*;

   if (CNT_W < 7) begin : g_chk
      $error("CNT_W cannot hold the longest half period");
   end

   logic [CNT_W-1:0] cnt_r;
   wire  [CNT_W-1:0] half = CNT_W'(half_period(rif.code));
   wire              last = (cnt_r == half - 1'b1);

   // Counter is held at zero between transfers so no stray edge appears
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST)
         cnt_r <= '0;
      else if (!rif.run || last)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   assign rif.tick = rif.run & last;

   a_clock_stopped: assert property (@(posedge I_REF_CLK)
      disable iff (!I_NRST) !rif.run |-> !rif.tick ##1 cnt_r == '0)
      else $error("divider ran while stopped");
endmodule

// ### test/spi_far_slave.sv
// Behavioural serial slave standing on the far side of the port
`timescale 1ns/100ps
module spi_far_slave (
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_sel_n,
   input  wire logic       i_clock_polarity_sel,
   input  wire logic       i_clock_phase_sel,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic            o_miso_oe,
   output logic [7:0]      o_rx
);
   logic [7:0] tx_r;
   logic [2:0] idx_r;
   logic       first_r;
   // Floats when not selected; the bench pull-up then sets the line
   assign o_miso_oe = ~i_sel_n;
   always @(negedge i_sel_n) begin
      tx_r = i_tx;
      idx_r = 3'h7;
      first_r = 1'h1;
      o_miso = i_tx[7];
   end
   // Leading edge samples in phase 0, trailing edge in phase 1
   always @(i_sck) begin
      if (!i_sel_n && ((i_sck ^ i_clock_polarity_sel) != i_clock_phase_sel)) begin
         o_rx = {o_rx[6:0], i_mosi};
      end else if (!i_sel_n) begin
         if (!(first_r && i_clock_phase_sel)) begin
            idx_r = idx_r - 3'h1;
         end
         first_r = 1'h0;
         o_miso = tx_r[idx_r];
      end
   end
endmodule

// ### test/tb_spi_master_slave_port.sv
// Bench for the serial port: register tasks, far slave, checks
`timescale 1ns/100ps
module tb_spi_master_slave_port;
   import spi_port_pkg::*;
   logic        clk = 1'h0;
   logic        nrst = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic        rd_en = 1'h0;
   logic        wr_en = 1'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic        imask = 1'h0;
   logic        ss_low = 1'h0;
   logic        far_clock_polarity_sel = 1'h0;
   logic        far_clock_phase_sel = 1'h0;
   logic [7:0]  far_tx = 8'h00;
   logic [31:0] rdata;
   logic        wreq, irq, far_miso, far_oe, miso_o, miso_oe, mosi_o;
   logic        mosi_oe, sck_o, sck_oe, ss_o, ss_oe;
   logic [7:0]  far_rx;
   int          errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          ratio [8] = '{2, 4, 16, 32, 8, 16, 64, 128};
   // Data and clock lines carry pull-ups, so they read high when released; a released select follows ss_low
   wire miso_w = miso_oe ? miso_o : (far_oe ? far_miso : 1'h1);
   wire mosi_w = mosi_oe ? mosi_o : 1'h1;
   wire sck_w  = sck_oe ? sck_o : 1'h1;
   wire ss_w   = ss_oe ? ss_o : ~ss_low;

   spi_master_slave_port dut (
      .I_REF_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
      .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(wreq), .I_CCR_IMASK(imask), .O_SPI_IRQ(irq),
      .I_MISO(miso_w), .O_MISO(miso_o), .O_MISO_OE(miso_oe),
      .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe),
      .I_SCK(sck_w), .O_SCK(sck_o), .O_SCK_OE(sck_oe),
      .I_SS_N(ss_w), .O_SS_N(ss_o), .O_SS_N_OE(ss_oe));

   spi_far_slave far (
      .i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(ss_w), .i_clock_polarity_sel(far_clock_polarity_sel),
      .i_clock_phase_sel(far_clock_phase_sel), .i_tx(far_tx), .o_miso(far_miso),
      .o_miso_oe(far_oe), .o_rx(far_rx));

   initial begin
      forever #5 clk = ~clk;
   end

   task report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Holds the request until waitrequest is seen low, then releases
   task automatic bus(input logic wr, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [7:0] v);
      addr <= {idx, 2'h0};
      wdata <= {24'h00_0000, wd};
      wr_en <= wr;
      rd_en <= ~wr;
      do @(posedge clk); while (wreq !== 1'h0);
      v = rdata[7:0];
      wr_en <= 1'h0;
      rd_en <= 1'h0;
      @(posedge clk);
   endtask

   task automatic wait_done(output logic [7:0] v);
      int n;
      n = 0;
      do begin
         bus(1'h0, IDX_STAT, 8'h00, v);
         n++;
      end while (v[7] !== 1'h1 && n < 400);
   endtask

   initial begin
      logic [7:0] v, mtx, ftx;
      int w;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      chk("pin_oe", 8'h00, {4'h0, miso_oe, mosi_oe, sck_oe, ss_oe});
      bus(1'h0, IDX_CTRL, 8'h00, v);
      chk("ctrl_rst", CTRL_RESET, v);
      bus(1'h0, IDX_STAT, 8'h00, v);
      chk("stat_rst", 8'h00, v);
      bus(1'h1, 6'h3F, 8'hFF, v);
      bus(1'h0, 6'h3F, 8'h00, v);
      chk("unmapped", 8'h00, v);
      for (int k = 0; k < 2; k++) begin
         bus(1'h1, IDX_CTRL, {2'h0, k[0], 5'h00}, v);
         bus(1'h1, IDX_DIR, 8'h3C, v);
         bus(1'h1, IDX_PORT, 8'h28, v);
         repeat (2) @(posedge clk);
         chk("port_pins", {4'h0, ~k[0], ~k[0], 2'h2},
             {4'h0, mosi_oe, mosi_o, sck_oe, sck_o});
      end
      // Every polarity and phase, every divide code once
      for (int i = 0; i < 8; i++) begin
         mtx = 8'h96 ^ 8'(i * 37);
         ftx = 8'h69 + 8'(i * 23);
         imask <= i[2];
         far_clock_polarity_sel <= i[1];
         far_clock_phase_sel <= i[0];
         far_tx <= ftx;
         bus(1'h1, IDX_OPT, {5'h00, i[2], 2'h0}, v);
         bus(1'h1, IDX_CTRL, {4'hD, i[1], i[0], i[1:0]}, v);
         bus(1'h1, IDX_DIR, 8'h38, v);
         bus(1'h1, IDX_PORT, 8'h20, v);
         bus(1'h1, IDX_PORT, 8'h00, v);
         chk("sck_idle", {7'h00, i[1]}, {7'h00, sck_w});
         bus(1'h1, IDX_DATA, mtx, v);
         w = 0;
         while (sck_w === i[1] && w < 300) begin
            @(negedge clk);
            w++;
         end
         w = 0;
         while (sck_w !== i[1] && w < 300) begin
            @(negedge clk);
            w++;
         end
         chk("half_period", 8'(ratio[i] / 2), 8'(w));
         @(posedge clk);
         wait_done(v);
         chk("status", 8'h80, v);
         chk("far_rx", mtx, far_rx);
         chk("irq", {7'h00, ~i[2]}, {7'h00, irq});
         bus(1'h0, IDX_DATA, 8'h00, v);
         chk("rx_data", ftx, v);
         bus(1'h0, IDX_STAT, 8'h00, v);
         chk("done_clr", 8'h00, v);
         chk("irq_clr", 8'h00, {7'h00, irq});
      end
      bus(1'h1, IDX_PORT, 8'h20, v);
      far_tx <= 8'h81;
      bus(1'h1, IDX_PORT, 8'h00, v);
      bus(1'h1, IDX_DATA, 8'hE7, v);
      bus(1'h1, IDX_DATA, 8'h18, v);
      wait_done(v);
      chk("collision", 8'hC0, v);
      chk("far_rx_col", 8'hE7, far_rx);
      bus(1'h0, IDX_DATA, 8'h00, v);
      chk("rx_col", 8'h81, v);
      imask <= 1'h0;
      bus(1'h1, IDX_CTRL, 8'hD0, v);
      bus(1'h1, IDX_DIR, 8'h18, v);
      ss_low <= 1'h1;
      repeat (6) @(posedge clk);
      bus(1'h0, IDX_STAT, 8'h00, v);
      chk("fault", 8'h10, v);
      bus(1'h0, IDX_CTRL, 8'h00, v);
      chk("fault_ctrl", 8'hC0, v);
      bus(1'h0, IDX_DIR, 8'h00, v);
      chk("fault_dir", 8'h00, v);
      chk("fault_irq", 8'h01, {7'h00, irq});
      imask <= 1'h1;
      repeat (3) @(posedge clk);
      chk("masked_irq", 8'h00, {7'h00, irq});
      ss_low <= 1'h0;
      bus(1'h1, IDX_CTRL, 8'h44, v);
      bus(1'h1, IDX_DIR, 8'h04, v);
      repeat (4) @(posedge clk);
      chk("miso_off", 8'h00, {7'h00, miso_oe});
      ss_low <= 1'h1;
      repeat (4) @(posedge clk);
      chk("miso_on", 8'h01, {7'h00, miso_oe});
      report_and_stop();
   end
endmodule
